// ### verilog/scc_strap_stop_ctrl.sv
// Strap decode, driver disable, halt and coil direct control
`timescale 1ns/10ps
`default_nettype none
`include "scc_cfg.svh"
module scc_strap_stop_ctrl
	import scc_pkg::*;
#(
	parameter int STOP_CYCLES = `SCC_OFF_SWITCH_CYCLES
) (
	input  wire logic        sys_clk_in,
	input  wire logic        resetn_in,
	input  wire logic        host_port_sel_in,
	input  wire logic [1:0]  off_time_strap_in,
	input  wire logic [1:0]  resolution_strap_a_in,
	input  wire logic [1:0]  resolution_strap_b_in,
	input  wire logic [1:0]  current_mode_strap_in,
	input  wire logic [1:0]  hysteresis_strap_in,
	input  wire logic [1:0]  blank_time_strap_in,
	input  wire logic [1:0]  enable_strap_in,
	input  wire logic        driver_disable_n_pin_in,
	input  wire logic        halt_input_in,
	input  wire logic        halt_enable_in,
	input  wire logic        direct_mode_in,
	input  wire logic        step_in,
	input  wire logic        dir_in,
	input  wire logic        standstill_in,
	input  wire logic        reg_wr_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic [4:0]  host_run_current_in,
	input  wire logic [4:0]  host_hold_current_in,
	input  wire logic [4:0]  pwm_cur_a_in,
	input  wire logic [4:0]  pwm_cur_b_in,
	input  wire logic        driver_error_in,
	input  wire logic        index_in,
	output logic [31:0]      reg_rdata_out,
	output logic             host_port_en_out,
	output scc_config_t      config_out,
	output logic             stage_enable_out,
	output logic             seq_step_out,
	output logic             seq_dir_out,
	output logic             seq_run_out,
	output logic             standstill_force_out,
	output scc_coil_t        coil_out,
	output logic [4:0]       current_scale_out,
	output logic [4:0]       pwm_reg_current_out,
	output logic             first_diag_out,
	output logic             first_diag_oe_n_out,
	output logic             second_diag_out,
	output logic             second_diag_oe_n_out
);

	localparam int CW = $clog2(STOP_CYCLES + 1);

	// Pin encoding: 2'b00 low, 2'b01 high, 2'b1x open
	function automatic scc_strap_t strap_decode(input logic [1:0] p);
		if (p[1]) begin
			return SCC_OPEN;
		end else if (p[0]) begin
			return SCC_HIGH;
		end else begin
			return SCC_LOW;
		end
	endfunction

	function automatic logic [8:0] coil_scale(input logic [8:0] v, input logic [4:0] s);
		logic signed [15:0] p;
		p = $signed(v) * $signed({1'b0, s});
		return p[13:5];
	endfunction

	logic        rst_meta_q, rst_sync_q;
	logic        sampled_q, sampled_d;
	scc_config_t cfg_q, cfg_d;
	logic [31:0] direct_q, direct_d;
	logic [CW-1:0] off_cnt_q, off_cnt_d;
	logic        stage_q, stage_d;
	logic        step_prev_q, step_prev_d;
	logic        boost_q, boost_d;
	scc_coil_t   coil_q, coil_d;
	logic [4:0]  scale_q, scale_d;
	logic [4:0]  pwm_q, pwm_d;
	logic        first_diag_out_q, first_diag_out_d, second_diag_out_q, second_diag_out_d;
	logic        strap_mode, halted, disable_req;
	logic [4:0]  run_cur, hold_cur;
	scc_strap_t  ra, rb, en_s;

	// Release reset through two flops so the core leaves reset on a clean edge
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign strap_mode = !host_port_sel_in;
	assign host_port_en_out = host_port_sel_in;

	// Strap capture, taken once after release
	always_comb begin
		cfg_d = cfg_q;
		sampled_d = 1'b1;
		ra = strap_decode(resolution_strap_a_in);
		rb = strap_decode(resolution_strap_b_in);
		en_s = strap_decode(enable_strap_in);
		if (!sampled_q && strap_mode) begin
			cfg_d = '0;
			cfg_d.fault_on_first_diag = 1'b1;
			cfg_d.index_on_second_diag = 1'b1;
			case (strap_decode(off_time_strap_in))
				SCC_LOW:  cfg_d.off_time_field = `SCC_OFF_TIME_FIELD_LOW;
				SCC_HIGH: cfg_d.off_time_field = `SCC_OFF_TIME_FIELD_HIGH;
				default:  cfg_d.off_time_field = `SCC_OFF_TIME_FIELD_OPEN;
			endcase
			case (strap_decode(hysteresis_strap_in))
				SCC_LOW:  cfg_d.hysteresis_end = `SCC_HYSTERESIS_END_LOW;
				SCC_HIGH: cfg_d.hysteresis_end = `SCC_HYSTERESIS_END_HIGH;
				default:  cfg_d.hysteresis_end = `SCC_HYSTERESIS_END_OPEN;
			endcase
			case (strap_decode(blank_time_strap_in))
				SCC_LOW:  cfg_d.blank_time_select = `SCC_TBL_LOW;
				SCC_HIGH: cfg_d.blank_time_select = `SCC_TBL_HIGH;
				default:  cfg_d.blank_time_select = `SCC_TBL_OPEN;
			endcase
			// Strap b is the upper digit of the resolution table
			case (rb)
				SCC_LOW: begin
					cfg_d.microstep_resolution = (ra == SCC_LOW) ? `SCC_MICROSTEP_RESOLUTION_FULL
						: `SCC_MICROSTEP_RESOLUTION_HALF;
					cfg_d.interpolate = (ra == SCC_OPEN);
				end
				SCC_HIGH: begin
					cfg_d.microstep_resolution = (ra == SCC_HIGH) ? `SCC_MICROSTEP_RESOLUTION_SIXTEENTH
						: `SCC_MICROSTEP_RESOLUTION_QUARTER;
					cfg_d.interpolate = (ra == SCC_OPEN);
				end
				default: begin
					cfg_d.microstep_resolution = (ra == SCC_HIGH) ? `SCC_MICROSTEP_RESOLUTION_QUARTER
						: `SCC_MICROSTEP_RESOLUTION_SIXTEENTH;
					cfg_d.interpolate = 1'b1;
					cfg_d.en_pwm_mode = (ra != SCC_LOW);
				end
			endcase
			case (en_s)
				SCC_LOW: begin
					cfg_d.run_current = `SCC_CUR_MAX;
					cfg_d.hold_current = `SCC_CUR_MAX;
				end
				SCC_HIGH: cfg_d.strap_disable = 1'b1;
				default: begin
					cfg_d.run_current = `SCC_CUR_MAX;
					cfg_d.hold_current = `SCC_CUR_HOLD_OPEN;
					cfg_d.hold_ramp_delay = `SCC_HOLD_DELAY_OPEN;
				end
			endcase
			case (strap_decode(current_mode_strap_in))
				SCC_LOW:  ;
				SCC_HIGH: cfg_d.internal_rsense = 1'b1;
				default:  cfg_d.scale_analog = 1'b1;
			endcase
		end
	end

	assign run_cur = strap_mode ? cfg_q.run_current : host_run_current_in;
	assign hold_cur = strap_mode ? cfg_q.hold_current : host_hold_current_in;
	assign halted = halt_enable_in && !halt_input_in;
	assign disable_req = driver_disable_n_pin_in || (strap_mode && cfg_q.strap_disable);

	// Stage shutdown counts up so the stages are off after the set number of edges
	always_comb begin
		off_cnt_d = off_cnt_q;
		stage_d = stage_q;
		if (disable_req) begin
			if (off_cnt_q == CW'(STOP_CYCLES - 1)) begin
				stage_d = 1'b0;
			end else begin
				off_cnt_d = off_cnt_q + CW'(1);
				stage_d = stage_q && (off_cnt_q < CW'(STOP_CYCLES - 1));
			end
		end else begin
			off_cnt_d = '0;
			// Held off until straps are known, so a strapped-off driver never pulses on
			stage_d = sampled_q;
		end
	end

	// Direct coil register and current scaling
	always_comb begin
		direct_d = direct_q;
		step_prev_d = step_in;
		boost_d = boost_q;
		pwm_d = pwm_q;
		if (reg_wr_in && reg_addr_in == `SCC_OFS_COIL_DIRECT && host_port_sel_in) begin
			direct_d = reg_wdata_in;
		end
		if (step_in && !step_prev_q && !halted) begin
			boost_d = 1'b1;
		end else if (standstill_in || halted) begin
			boost_d = 1'b0;
		end
		scale_d = boost_q ? run_cur : hold_cur;
		coil_d.coil_a = coil_scale(direct_q[`SCC_COIL_A_LSB +: 9], hold_cur);
		coil_d.coil_b = coil_scale(direct_q[`SCC_COIL_B_LSB +: 9], hold_cur);
		// Regulation follows the larger setting; both PWMs take the same scale
		pwm_d = (pwm_cur_a_in > pwm_cur_b_in) ? pwm_cur_a_in : pwm_cur_b_in;
		first_diag_out_d = !(cfg_q.fault_on_first_diag && driver_error_in);
		second_diag_out_d = !(cfg_q.index_on_second_diag && index_in);
	end

	always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			sampled_q <= 1'b0;
			cfg_q <= '0;
			direct_q <= '0;
			off_cnt_q <= '0;
			stage_q <= 1'b0;
			step_prev_q <= 1'b0;
			boost_q <= 1'b0;
			coil_q <= '0;
			scale_q <= '0;
			pwm_q <= '0;
			first_diag_out_q <= 1'b1;
			second_diag_out_q <= 1'b1;
		end else begin
			sampled_q <= sampled_d;
			cfg_q <= cfg_d;
			direct_q <= direct_d;
			off_cnt_q <= off_cnt_d;
			stage_q <= stage_d;
			step_prev_q <= step_prev_d;
			boost_q <= boost_d;
			coil_q <= coil_d;
			scale_q <= scale_d;
			pwm_q <= pwm_d;
			first_diag_out_q <= first_diag_out_d;
			second_diag_out_q <= second_diag_out_d;
		end
	end

	assign config_out = cfg_q;
	assign stage_enable_out = stage_q && !driver_disable_n_pin_in;
	assign seq_run_out = !direct_mode_in && !halted;
	assign seq_step_out = step_in && !direct_mode_in && !halted;
	assign seq_dir_out = dir_in && !direct_mode_in;
	assign standstill_force_out = halted;
	assign coil_out = direct_mode_in ? coil_q : '0;
	assign current_scale_out = scale_q;
	assign pwm_reg_current_out = pwm_q;
	assign reg_rdata_out = (reg_addr_in == `SCC_OFS_COIL_DIRECT) ? direct_q : '0;
	// Open drain: drive low only, release otherwise; pin level stays 0
	assign first_diag_out = 1'b0;
	assign first_diag_oe_n_out = first_diag_out_q;
	assign second_diag_out = 1'b0;
	assign second_diag_oe_n_out = second_diag_out_q;

endmodule
`default_nettype wire

// ### verilog/scc_cfg.svh
// Constants for the strap configuration and stop control block
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_OFS_COIL_DIRECT     8'h2D
`define SCC_COIL_A_LSB          0
`define SCC_COIL_B_LSB          16
`define SCC_OFF_SWITCH_CYCLES   3
`define SCC_OFF_TIME_FIELD_LOW            4'h4
`define SCC_OFF_TIME_FIELD_HIGH           4'h7
`define SCC_OFF_TIME_FIELD_OPEN           4'hA
`define SCC_HYSTERESIS_END_LOW            4'h7
`define SCC_HYSTERESIS_END_HIGH           4'hB
`define SCC_HYSTERESIS_END_OPEN           4'hF
`define SCC_TBL_LOW             2'h0
`define SCC_TBL_HIGH            2'h1
`define SCC_TBL_OPEN            2'h2
`define SCC_MICROSTEP_RESOLUTION_FULL           4'h8
`define SCC_MICROSTEP_RESOLUTION_HALF           4'h7
`define SCC_MICROSTEP_RESOLUTION_QUARTER        4'h6
`define SCC_MICROSTEP_RESOLUTION_SIXTEENTH      4'h4
`define SCC_CUR_MAX             5'h1F
`define SCC_CUR_HOLD_OPEN       5'h0B
`define SCC_HOLD_DELAY_OPEN     4'h8
`endif

// ### verilog/scc_pkg.sv
// Types for the strap configuration and stop control block
package scc_pkg;
	typedef enum logic [1:0] {SCC_LOW, SCC_HIGH, SCC_OPEN} scc_strap_t;
	typedef struct packed {
		logic [3:0] off_time_field;
		logic [3:0] hysteresis_end;
		logic [1:0] blank_time_select;
		logic [3:0] microstep_resolution;
		logic       interpolate;
		logic       en_pwm_mode;
		logic       strap_disable;
		logic [4:0] run_current;
		logic [4:0] hold_current;
		logic [3:0] hold_ramp_delay;
		logic       internal_rsense;
		logic       scale_analog;
		logic       fault_on_first_diag;
		logic       index_on_second_diag;
	} scc_config_t;
	typedef struct packed {
		logic signed [8:0] coil_a;
		logic signed [8:0] coil_b;
	} scc_coil_t;
endpackage

// ### verification/scc_sva.sv
// Checker for the strap and stop control ports
`timescale 1ns/10ps
`default_nettype none
module scc_sva
	import scc_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        resetn_in,
	input wire logic        host_port_sel_in,
	input wire logic        driver_disable_n_pin_in,
	input wire logic        halt_input_in,
	input wire logic        halt_enable_in,
	input wire logic        direct_mode_in,
	input wire logic        driver_error_in,
	input wire logic        host_port_en_out,
	input wire scc_config_t config_out,
	input wire logic        stage_enable_out,
	input wire logic        seq_step_out,
	input wire logic        seq_run_out,
	input wire logic        standstill_force_out,
	input wire scc_coil_t   coil_out,
	input wire logic        first_diag_oe_n_out
);
	logic [2:0] live_q;
	logic [2:0] live_d;
	// Skip the synchroniser and strap capture edges after each release
	always_comb begin
		live_d = (live_q == 3'h7) ? live_q : live_q + 3'h1;
	end
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			live_q <= 3'h0;
		end else begin
			live_q <= live_d;
		end
	end
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in || live_q != 3'h7);
	sequence s_stages_off;
		!stage_enable_out [*3];
	endsequence
	sequence s_halted;
		halt_enable_in && !halt_input_in;
	endsequence
	a_disable_stage_off: assert property (driver_disable_n_pin_in |-> !stage_enable_out)
		else $error("stage on while disable pin high");
	a_stop_within_three: assert property ($rose(driver_disable_n_pin_in) |-> s_stages_off)
		else $error("stages not off after disable");
	a_halt_stops_step: assert property (s_halted |-> standstill_force_out && !seq_step_out)
		else $error("halt did not stop stepping");
	a_direct_no_step: assert property (direct_mode_in |-> !seq_step_out && !seq_run_out)
		else $error("step passed in direct mode");
	a_direct_off_zero: assert property (!direct_mode_in [*3] |-> coil_out == '0)
		else $error("coil drive outside direct mode");
	a_host_port_follow: assert property (host_port_en_out == host_port_sel_in)
		else $error("host port enable wrong");
	a_strap_held: assert property ($stable(config_out))
		else $error("configuration changed after capture");
	a_strap_diag_flags: assert property (!host_port_sel_in |->
		config_out.fault_on_first_diag && config_out.index_on_second_diag)
		else $error("diag flags not set in strap mode");
	a_diag_open_drain: assert property (config_out.fault_on_first_diag && driver_error_in
		|=> !first_diag_oe_n_out)
		else $error("error not pulled onto first diag");
endmodule
bind scc_strap_stop_ctrl scc_sva i_sva (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
	.host_port_sel_in(host_port_sel_in), .driver_disable_n_pin_in(driver_disable_n_pin_in),
	.halt_input_in(halt_input_in), .halt_enable_in(halt_enable_in),
	.direct_mode_in(direct_mode_in), .driver_error_in(driver_error_in),
	.host_port_en_out(host_port_en_out), .config_out(config_out),
	.stage_enable_out(stage_enable_out), .seq_step_out(seq_step_out),
	.seq_run_out(seq_run_out), .standstill_force_out(standstill_force_out),
	.coil_out(coil_out), .first_diag_oe_n_out(first_diag_oe_n_out));
`default_nettype wire

// ### verification/scc_step_host.sv
// Step and direction source standing in for the motion controller
`timescale 1ns/10ps
`default_nettype none
module scc_step_host (
	input  wire logic clk_in,
	output logic      step_out,
	output logic      dir_out
);
	initial begin
		step_out = 1'b0;
		dir_out = 1'b0;
	end
	// Width in clocks lets a slow controller be modelled too
	task automatic pulse(input logic d, input int w);
		@(negedge clk_in);
		dir_out = d;
		step_out = 1'b1;
		repeat (w) @(negedge clk_in);
		step_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for strap and stop control
`timescale 1ns/10ps
`default_nettype none
module tb;
	import scc_pkg::*;
	localparam logic [35:0] MR = 36'h464646778;
	localparam logic [8:0] IP = 9'h1E4;
	localparam logic [11:0] OT = 12'hA74;
	localparam logic [11:0] HY = 12'hFB7;
	localparam logic [5:0] BT = 6'h24;
	logic clk = 0, rn = 0, hs = 0, dis = 0, hlt = 1, he = 0, dm = 0, ss = 0;
	logic wr = 0, er = 0, ix = 0, stp, dr, he_o, se, sq, sd, sr, sf, d1, o1, d2, o2;
	logic [1:0] st[7] = '{default: 2'h0};
	logic [7:0] ad = 8'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [4:0] rc = 5'h00, hc = 5'h00, pa = 5'h00, pb = 5'h00, cs, pr;
	scc_config_t cf;
	scc_coil_t co;
	int fail_count = 0, tests_run = 0, cyc = 0;
	always #2 clk = ~clk;
	scc_step_host i_host (.clk_in(clk), .step_out(stp), .dir_out(dr));
	scc_strap_stop_ctrl i_dut (.sys_clk_in(clk), .resetn_in(rn), .host_port_sel_in(hs),
		.off_time_strap_in(st[0]), .resolution_strap_a_in(st[1]), .resolution_strap_b_in(st[2]),
		.current_mode_strap_in(st[3]), .hysteresis_strap_in(st[4]), .blank_time_strap_in(st[5]),
		.enable_strap_in(st[6]), .driver_disable_n_pin_in(dis), .halt_input_in(hlt),
		.halt_enable_in(he), .direct_mode_in(dm), .step_in(stp), .dir_in(dr), .standstill_in(ss),
		.reg_wr_in(wr), .reg_addr_in(ad), .reg_wdata_in(wd), .host_run_current_in(rc),
		.host_hold_current_in(hc), .pwm_cur_a_in(pa), .pwm_cur_b_in(pb), .driver_error_in(er),
		.index_in(ix), .reg_rdata_out(rd), .host_port_en_out(he_o), .config_out(cf),
		.stage_enable_out(se), .seq_step_out(sq), .seq_dir_out(sd), .seq_run_out(sr),
		.standstill_force_out(sf), .coil_out(co), .current_scale_out(cs),
		.pwm_reg_current_out(pr), .first_diag_out(d1), .first_diag_oe_n_out(o1),
		.second_diag_out(d2), .second_diag_oe_n_out(o2));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			give_verdict();
		end
	end
	// Straps are only taken at start-up, so each setting needs its own reset
	task automatic rst(input logic h, input int a, input int b);
		@(negedge clk);
		rn = 0;
		hs = h;
		foreach (st[i]) st[i] = 2'(a);
		st[2] = 2'(b);
		repeat (6) @(negedge clk);
		rn = 1;
		repeat (5) @(negedge clk);
	endtask
	task automatic t_straps();
		int a;
		for (int i = 0; i < 9; i++) begin
			a = i % 3;
			rst(1'b0, a, i / 3);
			chk("res", {MR[4*i+:4], IP[i], i > 6},
				{cf.microstep_resolution, cf.interpolate, cf.en_pwm_mode});
			chk("chop", {OT[4*a+:4], HY[4*a+:4], BT[2*a+:2]},
				{cf.off_time_field, cf.hysteresis_end, cf.blank_time_select});
			chk("mode", {a == 1, a == 2, 2'h3, a == 1, a != 1, 1'b0}, {cf.internal_rsense,
				cf.scale_analog, cf.fault_on_first_diag, cf.index_on_second_diag,
				cf.strap_disable, se, he_o});
			if (a != 1) chk("cur", {5'h1F, a == 2 ? 5'h0B : 5'h1F},
				{cf.run_current, cf.hold_current});
		end
		chk("dly", 4'h8, cf.hold_ramp_delay);
		st[0] = 2'h0;
		er = 1;
		ix = 1;
		repeat (4) @(negedge clk);
		chk("held", {4'hA, 4'h0}, {cf.off_time_field, o1, o2, d1, d2});
		er = 0;
		ix = 0;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		ad = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic t_direct();
		rc = 5'h14;
		hc = 5'h10;
		rst(1'b1, 0, 0);
		chk("port", 1'b1, he_o);
		wr_reg(8'h2D, 32'h01C0_0064);
		wr_reg(8'h2C, 32'hFFFF_FFFF);
		ad = 8'h2D;
		dm = 1;
		repeat (3) @(negedge clk);
		chk("rd", 32'h01C0_0064, rd);
		chk("coil", {9'h032, 9'h1E0}, co);
		chk("hold", 5'h10, cs);
		i_host.pulse(1'b1, 1);
		repeat (3) @(negedge clk);
		chk("run", {5'h14, 3'h0}, {cs, sq, sr, sd});
		ss = 1;
		repeat (3) @(negedge clk);
		chk("drop", 5'h10, cs);
		ss = 0;
		dm = 0;
	endtask
	task automatic t_stop();
		chk("on", 1'b1, se);
		dis = 1;
		#1 chk("off", 1'b0, se);
		repeat (3) @(negedge clk);
		chk("off3", 1'b0, se);
		dis = 0;
		#1 chk("latch", 1'b0, se);
		repeat (2) @(negedge clk);
		chk("back", 1'b1, se);
		he = 1;
		for (int h = 0; h < 2; h++) begin
			hlt = h[0];
			fork
				i_host.pulse(h[0], 2);
				repeat (2) @(negedge clk);
			join_any
			chk("halt", {h[0], !h[0], h[0]}, {sq, sf, sd});
			repeat (2) @(negedge clk);
		end
		pa = 5'h05;
		pb = 5'h09;
		repeat (2) @(negedge clk);
		chk("pwm", 5'h09, pr);
		pa = 5'h0C;
		repeat (2) @(negedge clk);
		chk("pwm2", 5'h0C, pr);
	endtask
	initial begin
		t_straps();
		t_direct();
		t_stop();
		give_verdict();
	end
endmodule
`default_nettype wire
